// >>> dag_addr_gen.sv
/*
  Data-memory address generator: pointer pairs, virtual operands, indexed
  literal offset and the memory request toward data RAM.
  Assumes the core presents at most one data access per cycle and that the
  RAM answers a read combinationally in the same cycle as the request.
*/
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1: access-then-lower uses pointer, then decrements
// RULE2: access-then-raise uses pointer, then increments
// RULE3: raise-then-access increments, then uses pointer
// RULE4: indexed operand adds signed working register
// RULE5: plain and indexed operands change nothing
// RULE6: steps carry across the whole pair
// RULE7: pointer steps leave status flags alone
// RULE8: indirect read of virtual operand gives zero
// RULE9: indirect write to virtual operand is ignored
// RULE10: write to own pair stores without stepping
// RULE11: extended, forced access, field to 5Fh indexes
// RULE12: indexed address is frame pointer plus field
// RULE13: forced access high fields map bank 0/15
// RULE14: select bit set means banked direct addressing
// RULE15: inherent and literal operations are unaffected
// RULE16: extended mode leaves other pointers unchanged
// RULE17: low 96 access locations form frame window
// RULE18: remapping only for indexed literal offset
// RULE19: pointer is 12 bits, high nibble unused
// RULE20: indirect access ignores bank and select bit
// RULE21: indexed sum wraps, enable is static
// RULE22: pointer update lands in the access cycle
module dag_addr_gen
  import dag_pkg::*;
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  // configuration
  input  wire logic       i_ext_enable,
  // access request from the core
  input  wire logic       i_req_valid,
  input  wire dag_req_t   i_req,
  input  wire logic [3:0] i_bank_sel,
  input  wire dag_byte_t  i_wreg,
  // data RAM port
  output dag_mem_t        o_mem,
  input  wire dag_byte_t  i_mem_rdata,
  // read answer to the core
  output dag_byte_t       o_rdata,
  output logic            o_rdata_valid,
  // pointer pairs
  output dag_addr_t [NUM_PAIRS-1:0] o_ptrs
);

  dag_addr_t ptr_w [0:3];
  dag_pop_t  pop_w [0:NUM_PAIRS-1];

  // direct address of the request
  wire dag_addr_t dir_addr;
  wire logic      dir_indexed;

  dag_direct_map u_map (
    .i_acc_sel    (i_req.acc_sel),
    .i_file       (i_req.file),
    .i_bank_sel   (i_bank_sel),
    .i_ext_enable (i_ext_enable),
    .i_frame_ptr  (ptr_w[FRAME_PAIR]),
    .o_indexed    (dir_indexed),
    .o_addr       (dir_addr)
  );

  // virtual operand resolution; bank and select bit act only through the direct address
  wire dag_vdec_t vdec    = virt_decode(dir_addr);
  wire dag_addr_t sel_ptr = ptr_w[vdec.pair];
  wire dag_addr_t sext_w  = {{4{i_wreg[7]}}, i_wreg};
  wire dag_addr_t tgt_addr =
    (vdec.slot == SLOT_RAISE_THEN_ACCESS_OPERAND) ? sel_ptr + PTR_STEP :   // [RULE3]
    (vdec.slot == SLOT_ACCUMULATOR_INDEXED_OPERAND)  ? sel_ptr + sext_w   :   // [RULE4]
                                 sel_ptr;               // [RULE1] [RULE2] [RULE20]
  wire dag_addr_t eff_addr = vdec.hit ? tgt_addr : dir_addr;

  // pointer aimed at another virtual operand
  wire dag_vdec_t tdec    = virt_decode(tgt_addr);
  wire logic      blocked = vdec.hit && tdec.hit;       // [RULE8] [RULE9]

  // pointer bytes live here, not in RAM
  wire dag_pdec_t pdec      = ptr_decode(eff_addr);
  wire logic      ptr_hit   = i_req_valid && pdec.hit && !blocked;
  wire logic      ptr_wr    = ptr_hit && i_req.write;
  wire logic      own_clash = vdec.hit && ptr_wr && (pdec.pair == vdec.pair); // [RULE10]
  wire logic      steps     = i_req_valid && vdec.hit && !own_clash;
  wire dag_byte_t ptr_byte  = pdec.hi ? {4'h0, ptr_w[pdec.pair][11:8]} :    // [RULE19]
                                        ptr_w[pdec.pair][7:0];

  // RAM request
  wire logic      ram_go   = i_req_valid && !blocked && !pdec.hit;
  wire dag_mem_t  mem_d    = '{addr: eff_addr, re: ram_go && !i_req.write,
                               we: ram_go && i_req.write, wdata: i_req.wdata};
  wire logic      rd_issue = i_req_valid && !i_req.write;
  wire dag_rsrc_t rsrc_d   = ram_go ? RSRC_RAM : RSRC_LOCAL;
  wire dag_byte_t local_d  = blocked ? READ_BLOCKED : ptr_byte;  // [RULE8]

  assign ptr_w[3] = PTR_RESET;

  genvar n;
  generate
    for (n = 0; n < NUM_PAIRS; n++) begin : g_pair
      wire logic load_me = ptr_wr && (pdec.pair == 2'(n));
      wire logic step_me = steps && (vdec.pair == 2'(n));
      // only the stepped pair and the loaded pair move; others hold in any mode
      assign pop_w[n] =                                          // [RULE16]
        load_me ? (pdec.hi ? POP_LOAD_HI : POP_LOAD_LO) :       // [RULE10]
        !step_me ? POP_HOLD :
        (vdec.slot == SLOT_ACCESS_THEN_LOWER_OPERAND) ? POP_DEC :                  // [RULE1]
        (vdec.slot == SLOT_ACCESS_THEN_RAISE_OPERAND || vdec.slot == SLOT_RAISE_THEN_ACCESS_OPERAND) ?
          POP_INC : POP_HOLD;                                    // [RULE2] [RULE3] [RULE5]

      dag_ptr_pair u_ptr (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_op     (pop_w[n]),                                    // [RULE22]
        .i_wdata  (i_req.wdata),
        .o_ptr    (ptr_w[n])
      );

      assign o_ptrs[n] = ptr_w[n];
    end
  endgenerate

  // read answer pipeline
  logic      rd_pend_q;
  dag_rsrc_t rsrc_q;
  dag_byte_t local_q;

  // no request, no change: inherent and literal work never reaches here
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem     <= '0;
      rd_pend_q <= 1'b0;
      rsrc_q    <= RSRC_RAM;
      local_q   <= BYTE_RESET;
    end else begin
      o_mem     <= mem_d;                                        // [RULE15]
      rd_pend_q <= rd_issue;
      rsrc_q    <= rsrc_d;
      local_q   <= local_d;
    end
  end

  wire dag_byte_t rdata_d = (rsrc_q == RSRC_RAM) ? i_mem_rdata : local_q;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata       <= BYTE_RESET;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata       <= rdata_d;
      o_rdata_valid <= rd_pend_q;
    end
  end

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  wire logic via_slot  = i_req_valid && vdec.hit && !blocked && !pdec.hit && !own_clash;
  wire logic is_access_then_lower_operand = via_slot && vdec.slot == SLOT_ACCESS_THEN_LOWER_OPERAND;
  wire logic is_access_then_raise_operand = via_slot && vdec.slot == SLOT_ACCESS_THEN_RAISE_OPERAND;
  wire logic is_raise_then_access_operand  = via_slot && vdec.slot == SLOT_RAISE_THEN_ACCESS_OPERAND;
  wire logic is_accumulator_indexed_operand   = via_slot && vdec.slot == SLOT_ACCUMULATOR_INDEXED_OPERAND;
  wire logic is_direct  = i_req_valid && !vdec.hit && !pdec.hit;
  wire logic is_plain   = via_slot && vdec.slot == SLOT_PLAIN;
  wire logic is_forced  = is_direct && !i_req.acc_sel && !dir_indexed;

  sequence s_blocked_read;
    i_req_valid && !i_req.write && blocked;
  endsequence

  sequence s_zero_answer;
    ##2 o_rdata_valid && o_rdata == READ_BLOCKED;
  endsequence

  sequence s_blocked_plain;
    i_req_valid && blocked && vdec.slot == SLOT_PLAIN;
  endsequence

  sequence s_byte_load_lo;
    ptr_wr && !pdec.hi;
  endsequence

  sequence s_byte_load_hi;
    ptr_wr && pdec.hi;
  endsequence

  sequence s_own_write_hi;
    own_clash && pdec.hi;
  endsequence

  a_access_then_lower_operand_step: assert property (is_access_then_lower_operand |=> // [RULE1]
    o_mem.addr == $past(sel_ptr) && o_ptrs[$past(vdec.pair)] == $past(sel_ptr) - PTR_STEP)
    else $error("access-then-lower address or step wrong");

  a_access_then_raise_operand_step: assert property (is_access_then_raise_operand |=> // [RULE2]
    o_mem.addr == $past(sel_ptr) && o_ptrs[$past(vdec.pair)] == $past(sel_ptr) + PTR_STEP)
    else $error("access-then-raise address or step wrong");

  a_raise_then_access_operand_step: assert property (is_raise_then_access_operand |=> // [RULE3]
    o_mem.addr == $past(sel_ptr) + PTR_STEP && o_ptrs[$past(vdec.pair)] == o_mem.addr)
    else $error("raise-then-access address or step wrong");

  a_accumulator_indexed_operand_offset: assert property (is_accumulator_indexed_operand |=> // [RULE4]
    o_mem.addr == $past(sel_ptr) + $past(sext_w) && $stable(o_ptrs))
    else $error("indexed operand address wrong or pointer moved");

  a_blocked_read: assert property (s_blocked_read |-> s_zero_answer) // [RULE8]
    else $error("read through virtual operand not zero");

  a_blocked_write: assert property (i_req_valid && i_req.write && blocked |=> // [RULE9]
    !o_mem.we && !o_mem.re)
    else $error("write through virtual operand reached RAM");

  a_own_store_lo: assert property (own_clash && !pdec.hi |=> // [RULE10]
    o_ptrs[$past(vdec.pair)][7:0] == $past(i_req.wdata))
    else $error("own pair write did not store plainly");

  a_indexed_addr: assert property (is_direct && dir_indexed |=> // [RULE12]
    o_mem.addr == $past(ptr_w[FRAME_PAIR]) + {4'h0, $past(i_req.file)})
    else $error("indexed literal offset address wrong");

  a_banked_addr: assert property (is_direct && i_req.acc_sel |=> // [RULE14]
    o_mem.addr == {$past(i_bank_sel), $past(i_req.file)})
    else $error("banked direct address wrong");

  a_hi_nibble: assert property (i_req_valid && !i_req.write && ptr_hit && pdec.hi |-> // [RULE19]
    ##2 o_rdata_valid && o_rdata[7:4] == 4'h0)
    else $error("pointer high byte upper nibble not zero");

  a_plain_hold: assert property (is_plain |=> // [RULE5] [RULE20]
    o_mem.addr == $past(sel_ptr) && $stable(o_ptrs))
    else $error("plain operand address wrong or pointer moved");

  a_accumulator_indexed_operand_below: assert property (is_accumulator_indexed_operand && i_wreg[7] |=> // [RULE4]
    o_mem.addr == $past(sel_ptr) - (12'h100 - {4'h0, $past(i_wreg)}))
    else $error("negative indexed offset wrong");

  a_inc_carry: assert property (is_access_then_raise_operand && sel_ptr[7:0] == 8'hFF |=> // [RULE6]
    o_ptrs[$past(vdec.pair)][11:8] == $past(sel_ptr[11:8]) + 4'h1)
    else $error("increment did not carry into high byte");

  a_inc_low: assert property (is_access_then_raise_operand && sel_ptr[7:0] != 8'hFF |=> // [RULE6]
    o_ptrs[$past(vdec.pair)][11:8] == $past(sel_ptr[11:8]))
    else $error("increment without wrap changed high byte");

  a_dec_borrow: assert property (is_access_then_lower_operand && sel_ptr[7:0] == 8'h00 |=> // [RULE6]
    o_ptrs[$past(vdec.pair)][11:8] == $past(sel_ptr[11:8]) - 4'h1)
    else $error("decrement did not borrow from high byte");

  a_raise_then_access_operand_carry: assert property (is_raise_then_access_operand && sel_ptr[7:0] == 8'hFF |=> // [RULE3] [RULE6]
    o_mem.addr[11:8] == $past(sel_ptr[11:8]) + 4'h1)
    else $error("raise-then-access target did not carry");

  a_blocked_quiet: assert property (s_blocked_plain |=> // [RULE8] [RULE9]
    $stable(o_ptrs) && !o_mem.re && !o_mem.we)
    else $error("blocked plain access moved a pointer or reached RAM");

  a_own_store_hi: assert property (s_own_write_hi |=> // [RULE10]
    o_ptrs[$past(vdec.pair)][11:8] == $past(i_req.wdata[3:0]) &&
    o_ptrs[$past(vdec.pair)][7:0] == $past(sel_ptr[7:0]))
    else $error("own pair high write did not store plainly");

  a_load_lo: assert property (s_byte_load_lo |=> // [RULE19]
    o_ptrs[$past(pdec.pair)][7:0] == $past(i_req.wdata))
    else $error("pointer low byte load wrong");

  a_load_hi: assert property (s_byte_load_hi |=> // [RULE19]
    o_ptrs[$past(pdec.pair)][11:8] == $past(i_req.wdata[3:0]))
    else $error("pointer high byte load wrong");

  a_access_high: assert property (is_forced && i_req.file >= ACC_SPLIT |=> // [RULE13]
    o_mem.addr == {BANK_TOP, $past(i_req.file)})
    else $error("forced access high field not in top bank");

  a_access_low: assert property (is_forced && i_req.file < ACC_SPLIT |=> // [RULE13]
    o_mem.addr == {BANK_ZERO, $past(i_req.file)})
    else $error("forced access low field not in bank zero");

  a_window: assert property (is_direct && dir_indexed |=> // [RULE17]
    o_mem.addr - $past(ptr_w[FRAME_PAIR]) <= {4'h0, IDX_LIMIT})
    else $error("indexed access outside frame window");

  a_idle_quiet: assert property (!i_req_valid |=> !o_mem.re && !o_mem.we) // [RULE15]
    else $error("memory request without a core request");

  a_direct_hold: assert property (is_direct |=> $stable(o_ptrs)) // [RULE16]
    else $error("direct access moved a pointer");

  a_other_hold: assert property (via_slot && vdec.pair == 2'h0 |=> // [RULE16]
    $stable(o_ptrs[2:1]))
    else $error("step of first pair moved another pair");

  a_byte_local: assert property (i_req_valid && pdec.hit |=> // [RULE19]
    !o_mem.re && !o_mem.we)
    else $error("pointer byte access reached RAM");

  a_banked_plain: assert property (i_req_valid && i_req.acc_sel |-> // [RULE14] [RULE18]
    !dir_indexed)
    else $error("select bit set but indexed mode used");

endmodule : dag_addr_gen
`default_nettype wire

// >>> dag_direct_map.sv
/*
  Forms the data address of a file-field access: banked, access bank or indexed.
  Assumes the extended-set enable is static while requests run.
*/
`timescale 1ns/1ns
`default_nettype none
module dag_direct_map
  import dag_pkg::*;
(
  // instruction fields
  input  wire logic       i_acc_sel,
  input  wire dag_byte_t  i_file,
  input  wire logic [3:0] i_bank_sel,
  // configuration and frame pointer
  input  wire logic       i_ext_enable,
  input  wire dag_addr_t  i_frame_ptr,
  // resolved address
  output logic            o_indexed,
  output dag_addr_t       o_addr
);

  wire dag_addr_t banked_addr  = {i_bank_sel, i_file};                      // [RULE14]
  wire dag_addr_t access_addr  = (i_file >= ACC_SPLIT) ?
                                 {BANK_TOP, i_file} : {BANK_ZERO, i_file};  // [RULE13]
  wire dag_addr_t indexed_addr = i_frame_ptr + {4'h0, i_file};              // [RULE12] [RULE21]

  assign o_indexed = i_ext_enable && !i_acc_sel && (i_file <= IDX_LIMIT);   // [RULE11] [RULE17]
  assign o_addr    = i_acc_sel ? banked_addr :                              // [RULE18]
                     o_indexed ? indexed_addr : access_addr;

endmodule : dag_direct_map
`default_nettype wire

// >>> dag_pkg.sv
/*
  Shared constants, types and decode functions for the data-memory address generator.
  Assumes a 12-bit data space, 8-bit data and three pointer pairs.
*/
`default_nettype none
package dag_pkg;

  localparam int NUM_PAIRS = 3;
  localparam int NUM_SLOTS = 5;

  typedef logic [11:0] dag_addr_t;
  typedef logic [7:0]  dag_byte_t;

  // virtual operand block of each pair: plain at base, the rest below it
  localparam dag_addr_t PAIR_BASE [0:NUM_PAIRS-1] = '{12'hFEF, 12'hFE7, 12'hFDF};
  localparam dag_addr_t SECOND_PLAIN_ADDR = 12'hFE7;
  localparam dag_addr_t LO_OFS            = 12'h002;
  localparam dag_addr_t HI_OFS            = 12'h003;

  localparam dag_addr_t PTR_RESET    = 12'h000;
  localparam dag_addr_t PTR_STEP     = 12'h001;
  localparam dag_byte_t IDX_LIMIT    = 8'h5F;
  localparam dag_byte_t ACC_SPLIT    = 8'h80;
  localparam logic [3:0] BANK_TOP    = 4'hF;
  localparam logic [3:0] BANK_ZERO   = 4'h0;
  localparam dag_byte_t READ_BLOCKED = 8'h00;
  localparam dag_byte_t BYTE_RESET   = 8'h00;
  localparam int        FRAME_PAIR   = 2;

  typedef enum logic [2:0] {
    SLOT_PLAIN, SLOT_ACCESS_THEN_LOWER_OPERAND, SLOT_ACCESS_THEN_RAISE_OPERAND, SLOT_RAISE_THEN_ACCESS_OPERAND, SLOT_ACCUMULATOR_INDEXED_OPERAND
  } dag_slot_t;

  typedef enum logic [2:0] {
    POP_HOLD, POP_DEC, POP_INC, POP_LOAD_LO, POP_LOAD_HI
  } dag_pop_t;

  typedef enum logic {RSRC_RAM, RSRC_LOCAL} dag_rsrc_t;

  typedef struct packed {
    logic      write;
    logic      acc_sel;
    dag_byte_t file;
    dag_byte_t wdata;
  } dag_req_t;

  typedef struct packed {
    dag_addr_t addr;
    logic      re;
    logic      we;
    dag_byte_t wdata;
  } dag_mem_t;

  typedef struct packed {
    logic      hit;
    logic [1:0] pair;
    dag_slot_t slot;
  } dag_vdec_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] pair;
    logic       hi;
  } dag_pdec_t;

  function automatic dag_vdec_t virt_decode(input dag_addr_t a);
    virt_decode = '{hit: 1'b0, pair: 2'h0, slot: SLOT_PLAIN};
    for (int p = 0; p < NUM_PAIRS; p++) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (a == PAIR_BASE[p] - 12'(s)) begin
          virt_decode = '{hit: 1'b1, pair: 2'(p), slot: dag_slot_t'(s)};
        end
      end
    end
  endfunction : virt_decode

  function automatic dag_pdec_t ptr_decode(input dag_addr_t a);
    ptr_decode = '{hit: 1'b0, pair: 2'h0, hi: 1'b0};
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (a == PAIR_BASE[p] + LO_OFS) ptr_decode = '{hit: 1'b1, pair: 2'(p), hi: 1'b0};
      if (a == PAIR_BASE[p] + HI_OFS) ptr_decode = '{hit: 1'b1, pair: 2'(p), hi: 1'b1};
    end
  endfunction : ptr_decode

endpackage : dag_pkg
`default_nettype wire

// >>> dag_ptr_pair.sv
/*
  One 12-bit pointer pair with byte loads and whole-pair steps.
  Assumes the caller issues at most one operation per cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module dag_ptr_pair
  import dag_pkg::*;
(
  // clock and reset
  input  wire logic      i_mclk,
  input  wire logic      i_resetn,
  // operation
  input  wire dag_pop_t  i_op,
  input  wire dag_byte_t i_wdata,
  // pointer value
  output var  dag_addr_t o_ptr
);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ptr <= PTR_RESET;
    end else begin
      unique case (i_op)
        POP_HOLD:    o_ptr <= o_ptr;
        POP_DEC:     o_ptr <= o_ptr - PTR_STEP;      // [RULE6] [RULE7]
        POP_INC:     o_ptr <= o_ptr + PTR_STEP;      // [RULE6] [RULE7]
        POP_LOAD_LO: o_ptr <= {o_ptr[11:8], i_wdata};
        POP_LOAD_HI: o_ptr <= {i_wdata[3:0], o_ptr[7:0]}; // [RULE19]
        default:     o_ptr <= o_ptr;
      endcase
    end
  end

endmodule : dag_ptr_pair
`default_nettype wire

// >>> dag_ram_model.sv
/*
  Behavioural data RAM on the far side of the address generator.
  Assumes a combinational read answer while re is high.
*/
`timescale 1ns/1ns
`default_nettype none
module dag_ram_model
  import dag_pkg::*;
(
  // clock
  input  wire logic      i_mclk,
  // request and answer
  input  wire dag_mem_t  i_mem,
  output dag_byte_t      o_rdata
);
  dag_byte_t ram [0:4095];
  dag_byte_t last_q;

  initial begin
    for (int k = 0; k < 4096; k++) ram[k] = 8'h00;
    last_q = 8'h00;
  end

  always @(posedge i_mclk) begin
    if (i_mem.we) ram[i_mem.addr] <= i_mem.wdata;
    if (i_mem.re) last_q <= ram[i_mem.addr];
  end

  // idle bus shows the inverse of the last answer
  assign o_rdata = i_mem.re ? ram[i_mem.addr] : ~last_q;
endmodule : dag_ram_model
`default_nettype wire

// >>> tb_dag_addr_gen.sv
/*
  Self-checking bench for the address generator.
  Assumes the 2-cycle read answer and the pointer byte map of the design.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_dag_addr_gen
  import dag_pkg::*;
;
  logic                      i_mclk;
  logic                      i_resetn;
  logic                      ext;
  logic                      valid;
  dag_req_t                  req;
  logic [3:0]                bank;
  dag_byte_t                 wreg;
  dag_mem_t                  mem;
  dag_byte_t                 ram_rdata;
  dag_byte_t                 rdata;
  logic                      rv;
  dag_addr_t [NUM_PAIRS-1:0] ptrs;
  int                        mismatches;
  int                        samples_checked;

  dag_addr_gen dag_addr_gen_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ext_enable(ext),
    .i_req_valid(valid), .i_req(req), .i_bank_sel(bank), .i_wreg(wreg), .o_mem(mem),
    .i_mem_rdata(ram_rdata), .o_rdata(rdata), .o_rdata_valid(rv), .o_ptrs(ptrs));
  dag_ram_model dag_ram_model_i (.i_mclk(i_mclk), .i_mem(mem), .o_rdata(ram_rdata));

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic chk_a(input string n, input dag_addr_t e, input dag_addr_t g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_a

  task automatic chk_b(input string n, input dag_byte_t e, input dag_byte_t g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_b

  // one access; ego says whether it must reach the RAM
  task automatic acc(input logic w, input logic a, input logic [3:0] bk, input dag_byte_t f,
                     input dag_byte_t wd, input dag_addr_t ea, input logic ego,
                     input dag_byte_t erd);
    @(posedge i_mclk);
    valid <= 1'b1;
    req   <= '{write: w, acc_sel: a, file: f, wdata: wd};
    bank  <= bk;
    @(posedge i_mclk);
    valid <= 1'b0;
    #1;
    chk_b("mem_re", 8'(ego & ~w), 8'(mem.re));
    chk_b("mem_we", 8'(ego & w), 8'(mem.we));
    if (ego) chk_a("mem_addr", ea, mem.addr);
    if (ego & w) chk_b("mem_wdata", wd, mem.wdata);
    @(posedge i_mclk);
    #1;
    chk_b("rdata_valid", 8'(!w), 8'(rv));
    chk_b("mem_idle", 8'h00, 8'({mem.re, mem.we}));
    if (!w) chk_b("rdata", erd, rdata);
  endtask : acc

  // loads a pointer through its low and high byte addresses
  task automatic setp(input dag_byte_t lof, input dag_addr_t v);
    acc(1'b1, 1'b0, 4'h0, lof, v[7:0], 12'h000, 1'b0, 8'h00);
    acc(1'b1, 1'b0, 4'h0, lof + 8'h01, {4'h0, v[11:8]}, 12'h000, 1'b0, 8'h00);
  endtask : setp

  task automatic finish_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    mismatches      = 0;
    samples_checked = 0;
    i_resetn = 1'b0;
    ext      = 1'b0;
    valid    = 1'b0;
    req      = '0;
    bank     = 4'h0;
    wreg     = 8'h00;
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    #1;
    for (int p = 0; p < NUM_PAIRS; p++) chk_a("ptr_reset", 12'h000, ptrs[p]);
    setp(8'hF1, 12'h0FF);
    acc(1'b1, 1'b0, 4'h0, 8'hED, 8'h5A, 12'h0FF, 1'b1, 8'h00);
    chk_a("ptr0", 12'h100, ptrs[0]);
    acc(1'b1, 1'b0, 4'h0, 8'hEE, 8'h3C, 12'h100, 1'b1, 8'h00);
    chk_a("ptr0", 12'h0FF, ptrs[0]);
    acc(1'b0, 1'b0, 4'h0, 8'hEC, 8'h00, 12'h100, 1'b1, 8'h3C);
    @(posedge i_mclk);
    wreg <= 8'hFF;
    acc(1'b0, 1'b1, 4'hF, 8'hEB, 8'h00, 12'h0FF, 1'b1, 8'h5A);
    @(posedge i_mclk);
    wreg <= 8'h81;
    acc(1'b0, 1'b0, 4'h6, 8'hEB, 8'h00, 12'h081, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 4'h0, 8'hEF, 8'h00, 12'h100, 1'b1, 8'h3C);
    chk_a("ptr0", 12'h100, ptrs[0]);
    acc(1'b1, 1'b1, 4'h3, 8'h10, 8'hA5, 12'h310, 1'b1, 8'h00);
    acc(1'b0, 1'b1, 4'h3, 8'h10, 8'h00, 12'h310, 1'b1, 8'hA5);
    setp(8'hF1, SECOND_PLAIN_ADDR);
    acc(1'b0, 1'b0, 4'h0, 8'hEF, 8'h00, 12'h000, 1'b0, 8'h00);
    acc(1'b1, 1'b0, 4'h0, 8'hEF, 8'h99, 12'h000, 1'b0, 8'h00);
    acc(1'b0, 1'b0, 4'h0, 8'hF2, 8'h00, 12'h000, 1'b0, 8'h0F);
    setp(8'hE1, 12'hFE1);
    acc(1'b1, 1'b0, 4'h0, 8'hDE, 8'h34, 12'h000, 1'b0, 8'h00);
    chk_a("ptr2", 12'hF34, ptrs[2]);
    setp(8'hE1, 12'hFE2);
    acc(1'b1, 1'b0, 4'h0, 8'hDF, 8'h03, 12'h000, 1'b0, 8'h00);
    chk_a("ptr2", 12'h3E2, ptrs[2]);
    @(posedge i_mclk);
    ext <= 1'b1;
    setp(8'hE1, 12'h200);
    acc(1'b1, 1'b0, 4'h0, 8'h00, 8'h77, 12'h200, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 4'h0, 8'h5F, 8'h00, 12'h25F, 1'b1, 8'h00);
    acc(1'b0, 1'b1, 4'h2, 8'h00, 8'h00, 12'h200, 1'b1, 8'h77);
    acc(1'b0, 1'b0, 4'h0, 8'h60, 8'h00, 12'h060, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 4'h0, 8'hFF, 8'h00, 12'hFFF, 1'b1, 8'h00);
    acc(1'b1, 1'b0, 4'h0, 8'hE5, 8'h66, 12'h000, 1'b1, 8'h00);
    chk_a("ptr1", 12'h001, ptrs[1]);
    setp(8'hE1, 12'hFF0);
    acc(1'b0, 1'b0, 4'h0, 8'h20, 8'h00, 12'h010, 1'b1, 8'h00);
    @(posedge i_mclk);
    ext <= 1'b0;
    acc(1'b0, 1'b0, 4'h0, 8'h20, 8'h00, 12'h020, 1'b1, 8'h00);
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    @(posedge i_mclk);
    i_resetn <= 1'b1;
    #1;
    chk_a("ptr2_reset", 12'h000, ptrs[2]);
    finish_test;
  end
endmodule : tb_dag_addr_gen
`default_nettype wire
